// ### dpb_pkg.sv
// shared constants and carrier types of the drive parameter and bus select bank
package dpb_pkg;
  localparam logic [15:0] IDX_TORQUE_BAND   = 16'h203d;
  localparam logic [15:0] IDX_TORQUE_DWELL  = 16'h203e;
  localparam logic [15:0] IDX_SLIP_DELAY    = 16'h203f;
  localparam logic [15:0] IDX_PULSE_MULT    = 16'h2057;
  localparam logic [15:0] IDX_PULSE_DIV     = 16'h2058;
  localparam logic [15:0] IDX_BOOT_POS      = 16'h205a;
  localparam logic [15:0] IDX_INPUT_MODE    = 16'h205b;
  localparam logic [15:0] IDX_READY_DELAY   = 16'h2084;
  localparam logic [15:0] IDX_BUS_PRESENCE  = 16'h2101;
  localparam logic [15:0] IDX_BUS_SELECT    = 16'h2102;

  localparam logic [15:0] RST_TORQUE_BAND   = 16'h0000;
  localparam logic [15:0] RST_TORQUE_DWELL  = 16'h0000;
  localparam logic [15:0] RST_SLIP_DELAY    = 16'h0064;
  localparam logic [31:0] RST_PULSE_MULT    = 32'h0000_0080;
  localparam logic [31:0] RST_PULSE_DIV     = 32'h0000_0001;
  localparam logic [31:0] RST_BOOT_POS      = 32'h0000_0000;
  localparam logic [31:0] RST_INPUT_MODE    = 32'h0000_0000;
  localparam logic [31:0] RST_READY_DELAY   = 32'h0000_0000;
  localparam logic [31:0] RST_BUS_PRESENCE  = 32'h0000_0008;
  localparam logic [31:0] RST_BUS_SELECT    = 32'h0000_0008;
  localparam logic [31:0] RST_BUS_DISABLE   = 32'h0000_0000;
  localparam logic [31:0] RST_BUS_ENABLED   = 32'h0000_0008;
  localparam logic [15:0] BAND_OFF          = 16'hffff;

  // availability / select / status bit positions
  localparam int BIT_USB                          = 0;
  localparam int BIT_RS485                        = 1;
  localparam int BIT_RS232                        = 2;
  localparam int BIT_CAN                          = 3;
  localparam int ethernet_port_bit                = 4;
  localparam int industrial_ethernet_port_bit     = 5;
  localparam int BIT_SPI                          = 6;
  localparam int serial_modbus_protocol_bit       = 16;
  localparam int network_modbus_protocol_bit      = 17;
  localparam int industrial_ip_protocol_bit       = 18;
  localparam logic [31:0] PHYS_FIELD              = 32'h0000_ffff;
  localparam logic [31:0] PROTO_FIELD             = 32'hffff_0000;
  localparam int STATUS_SLIP_BIT                  = 13;

  localparam int MS_NS        = 1000000;
  localparam int CLK_NS       = 20;
  localparam int CYC_PER_MS   = MS_NS / CLK_NS;

  localparam logic INPUT_PULSE_DIR = 1'b0;
  localparam logic INPUT_CW_CCW    = 1'b1;

  typedef struct packed {
    logic        we;
    logic [15:0] index;
    logic [31:0] wdata;
  } dpb_od_req_s;
endpackage

// ### dpb_bank.sv
// drive parameter objects, torque and slip monitors, pulse scaling and bus select
`timescale 1ns/100ps
module dpb_bank
  import dpb_pkg::*;
#(
  parameter int          MS_CYCLES    = CYC_PER_MS,
  parameter logic [31:0] PRESENCE_MAP = RST_BUS_PRESENCE,
  parameter logic [31:0] DISABLE_MASK = RST_BUS_DISABLE
) (
  // clock and reset
  input  wire logic               CLK,
  input  wire logic               ARST_N,
  // object dictionary access
  input  wire logic               OD_REQ,
  input  wire dpb_od_req_s        OD_CMD,
  output logic                    OD_ACK,
  output logic                    OD_ERR,
  output logic [31:0]             OD_RDATA,
  // torque monitor
  input  wire logic signed [15:0] TORQUE_TARGET,
  input  wire logic signed [15:0] TORQUE_ACTUAL,
  output logic                    TORQUE_REACHED,
  // slip monitor
  input  wire logic               PV_MODE,
  input  wire logic signed [31:0] SPEED_DEVIATION,
  input  wire logic signed [31:0] SLIP_LIMIT,
  input  wire logic               SLIP_REACTION_EN,
  output logic                    STATUS_SLIP,
  output logic                    SLIP_REACTION_REQ,
  output logic                    ERR_LOG_PULSE,
  // pulse input scaling
  input  wire logic signed [31:0] PULSE_COUNT,
  output logic                    PULSE_CW_CCW,
  output logic signed [31:0]      PULSE_SCALED,
  // power-on position and readiness
  input  wire logic signed [31:0] ENCODER_POS,
  output logic                    DEVICE_READY,
  // fieldbus status
  output logic [31:0]             BUS_ENABLED
);

  // elaboration checks; the tick divider is only 17 bits wide
  if (MS_CYCLES < 1 || MS_CYCLES > 65536) begin
    $error("MS_CYCLES out of range");
  end
  if ((PRESENCE_MAP & ~(PHYS_FIELD | PROTO_FIELD)) != 32'h0000_0000) begin
    $error("PRESENCE_MAP malformed");
  end

  logic [15:0]        band_reg;
  logic [15:0]        dwell_reg;
  logic [15:0]        slip_delay_reg;
  logic signed [31:0] mult_reg;
  logic signed [31:0] div_reg;
  logic [31:0]        mode_reg;
  logic [31:0]        ready_delay_reg;
  logic [31:0]        select_reg;
  logic signed [31:0] boot_pos_reg;
  logic               boot_done_reg;
  logic [16:0]        ms_div_reg;
  logic               ms_tick_reg;
  logic [15:0]        torque_ms_reg;
  logic [15:0]        slip_ms_reg;
  logic [31:0]        boot_ms_reg;
  logic signed [63:0] product_reg;
  logic [31:0]        rdata_next;
  logic               hit_next;

  function automatic logic is_write(input dpb_od_req_s c, input logic req, input logic [15:0] idx);
    is_write = req && c.we && (c.index == idx);
  endfunction

  // millisecond tick shared by every time-based monitor
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ms_div_reg  <= 17'h0_0000;
      ms_tick_reg <= 1'b0;
    end else if (ms_div_reg == 17'(MS_CYCLES - 1)) begin
      ms_div_reg  <= 17'h0_0000;
      ms_tick_reg <= 1'b1;
    end else begin
      ms_div_reg  <= ms_div_reg + 17'h0_0001;
      ms_tick_reg <= 1'b0;
    end
  end

  // writable objects; read-only ones have no write path at all
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      band_reg        <= RST_TORQUE_BAND;
      dwell_reg       <= RST_TORQUE_DWELL;
      slip_delay_reg  <= RST_SLIP_DELAY;
      mult_reg        <= RST_PULSE_MULT;
      div_reg         <= RST_PULSE_DIV;
      mode_reg        <= RST_INPUT_MODE;
      ready_delay_reg <= RST_READY_DELAY;
      select_reg      <= RST_BUS_SELECT;
    end else begin
      if (is_write(OD_CMD, OD_REQ, IDX_TORQUE_BAND))  band_reg        <= OD_CMD.wdata[15:0];
      if (is_write(OD_CMD, OD_REQ, IDX_TORQUE_DWELL)) dwell_reg       <= OD_CMD.wdata[15:0];
      if (is_write(OD_CMD, OD_REQ, IDX_SLIP_DELAY))   slip_delay_reg  <= OD_CMD.wdata[15:0];
      if (is_write(OD_CMD, OD_REQ, IDX_PULSE_MULT))   mult_reg        <= OD_CMD.wdata;
      if (is_write(OD_CMD, OD_REQ, IDX_PULSE_DIV))    div_reg         <= OD_CMD.wdata;
      if (is_write(OD_CMD, OD_REQ, IDX_INPUT_MODE))   mode_reg        <= OD_CMD.wdata;
      if (is_write(OD_CMD, OD_REQ, IDX_READY_DELAY))  ready_delay_reg <= OD_CMD.wdata;
      if (is_write(OD_CMD, OD_REQ, IDX_BUS_SELECT))   select_reg      <= OD_CMD.wdata;
    end
  end

  // read decode
  always_comb begin
    rdata_next = 32'h0000_0000;
    hit_next   = 1'b1;
    case (OD_CMD.index)
      IDX_TORQUE_BAND:  rdata_next = {16'h0000, band_reg};
      IDX_TORQUE_DWELL: rdata_next = {16'h0000, dwell_reg};
      IDX_SLIP_DELAY:   rdata_next = {16'h0000, slip_delay_reg};
      IDX_PULSE_MULT:   rdata_next = mult_reg;
      IDX_PULSE_DIV:    rdata_next = div_reg;
      IDX_BOOT_POS:     rdata_next = boot_pos_reg;
      IDX_INPUT_MODE:   rdata_next = mode_reg;
      IDX_READY_DELAY:  rdata_next = ready_delay_reg;
      IDX_BUS_PRESENCE: rdata_next = PRESENCE_MAP;
      IDX_BUS_SELECT:   rdata_next = select_reg;
      default:          hit_next   = 1'b0;
    endcase
  end

  // one-cycle answer; unknown index answers with an error pulse, and with zero data on a read
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      OD_ACK   <= 1'b0;
      OD_ERR   <= 1'b0;
      OD_RDATA <= 32'h0000_0000;
    end else begin
      OD_ACK   <= OD_REQ && hit_next;
      OD_ERR   <= OD_REQ && !hit_next;
      OD_RDATA <= (OD_REQ && !OD_CMD.we) ? rdata_next : OD_RDATA;
    end
  end

  // torque window: 17-bit difference so a full-scale swing cannot wrap
  logic signed [16:0] t_diff;
  logic [16:0]        t_abs;
  logic               t_in_band;
  assign t_diff    = 17'(TORQUE_ACTUAL) - 17'(TORQUE_TARGET);
  assign t_abs     = t_diff[16] ? 17'(-t_diff) : 17'(t_diff);
  assign t_in_band = (t_abs <= {1'b0, band_reg});

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      torque_ms_reg  <= 16'h0000;
      TORQUE_REACHED <= 1'b0;
    end else begin
      if (!t_in_band) torque_ms_reg <= 16'h0000;
      else if (ms_tick_reg && torque_ms_reg != 16'hffff) torque_ms_reg <= torque_ms_reg + 16'h0001;
      TORQUE_REACHED <= (band_reg != BAND_OFF) && t_in_band
                        && (torque_ms_reg >= dwell_reg);
    end
  end

  // slip watchdog; both operands taken as magnitudes
  logic [31:0] s_abs;
  logic [31:0] s_lim;
  logic        s_over;
  assign s_abs  = SPEED_DEVIATION[31] ? 32'(-SPEED_DEVIATION) : 32'(SPEED_DEVIATION);
  assign s_lim  = SLIP_LIMIT[31] ? 32'(-SLIP_LIMIT) : 32'(SLIP_LIMIT);
  assign s_over = PV_MODE && (s_abs > s_lim);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      slip_ms_reg       <= 16'h0000;
      STATUS_SLIP       <= 1'b0;
      SLIP_REACTION_REQ <= 1'b0;
      ERR_LOG_PULSE     <= 1'b0;
    end else begin
      if (!s_over) slip_ms_reg <= 16'h0000;
      else if (ms_tick_reg && slip_ms_reg != 16'hffff) slip_ms_reg <= slip_ms_reg + 16'h0001;
      STATUS_SLIP       <= s_over && (slip_ms_reg > slip_delay_reg);
      SLIP_REACTION_REQ <= SLIP_REACTION_EN && s_over && (slip_ms_reg > slip_delay_reg)
                           && !STATUS_SLIP;
      ERR_LOG_PULSE     <= SLIP_REACTION_EN && s_over && (slip_ms_reg > slip_delay_reg)
                           && !STATUS_SLIP;
    end
  end

  // pulse scaling in two stages; a zero divider holds the last result
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      product_reg  <= 64'sh0;
      PULSE_SCALED <= 32'sh0;
      PULSE_CW_CCW <= INPUT_PULSE_DIR;
    end else begin
      product_reg  <= 64'(PULSE_COUNT) * 64'(mult_reg);
      if (div_reg != 32'sh0) PULSE_SCALED <= 32'(product_reg / 64'(div_reg));
      PULSE_CW_CCW <= mode_reg[0] ? INPUT_CW_CCW : INPUT_PULSE_DIR;
    end
  end

  // power-on position caught on the first edge after reset release
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      boot_pos_reg  <= RST_BOOT_POS;
      boot_done_reg <= 1'b0;
    end else if (!boot_done_reg) begin
      boot_pos_reg  <= ENCODER_POS;
      boot_done_reg <= 1'b1;
    end
  end

  // readiness: delay counted from reset release, and latched once reached
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      boot_ms_reg  <= 32'h0000_0000;
      DEVICE_READY <= 1'b0;
    end else if (!DEVICE_READY) begin
      if (ms_tick_reg) boot_ms_reg <= boot_ms_reg + 32'h0000_0001;
      DEVICE_READY <= (boot_ms_reg >= ready_delay_reg);
    end
  end

  // active buses: only maskable bits follow the select word, rest keep their state
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      BUS_ENABLED <= RST_BUS_ENABLED;
    end else begin
      BUS_ENABLED <= PRESENCE_MAP & ((select_reg & DISABLE_MASK)
                     | (BUS_ENABLED & ~DISABLE_MASK));
    end
  end

  property p_band_off;
    @(posedge CLK) disable iff (!ARST_N) (band_reg == BAND_OFF) |=> !TORQUE_REACHED;
  endproperty
  a_band_off: assert property (p_band_off) else $error("reached while monitoring off");

  property p_reach_in_band;
    @(posedge CLK) disable iff (!ARST_N) $rose(TORQUE_REACHED) |-> $past(t_in_band);
  endproperty
  a_reach_in_band: assert property (p_reach_in_band) else $error("reached outside band");

  property p_dwell;
    @(posedge CLK) disable iff (!ARST_N) TORQUE_REACHED |-> $past(torque_ms_reg) >= $past(dwell_reg);
  endproperty
  a_dwell: assert property (p_dwell) else $error("reached before dwell");

  property p_slip_mode;
    @(posedge CLK) disable iff (!ARST_N) !PV_MODE |=> !STATUS_SLIP;
  endproperty
  a_slip_mode: assert property (p_slip_mode) else $error("slip flag outside velocity mode");

  property p_slip_time;
    @(posedge CLK) disable iff (!ARST_N) $rose(STATUS_SLIP) |-> $past(slip_ms_reg) > $past(slip_delay_reg);
  endproperty
  a_slip_time: assert property (p_slip_time) else $error("slip flag before timeout");

  property p_reaction;
    @(posedge CLK) disable iff (!ARST_N) SLIP_REACTION_REQ |-> ERR_LOG_PULSE && STATUS_SLIP ##1 !SLIP_REACTION_REQ;
  endproperty
  a_reaction: assert property (p_reaction) else $error("reaction without log entry");

  property p_mode;
    @(posedge CLK) disable iff (!ARST_N) ##1 PULSE_CW_CCW == $past(mode_reg[0]);
  endproperty
  a_mode: assert property (p_mode) else $error("input mode not following selector");

  property p_boot_pos;
    @(posedge CLK) disable iff (!ARST_N) boot_done_reg |=> $stable(boot_pos_reg);
  endproperty
  a_boot_pos: assert property (p_boot_pos) else $error("boot position changed");

  property p_ready_hold;
    @(posedge CLK) disable iff (!ARST_N) DEVICE_READY |=> DEVICE_READY;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("ready dropped");

  property p_mask;
    @(posedge CLK) disable iff (!ARST_N) ##1 ((BUS_ENABLED ^ $past(BUS_ENABLED)) & ~DISABLE_MASK) == 32'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("unmaskable bus bit changed");

  property p_presence_read;
    @(posedge CLK) disable iff (!ARST_N)
      OD_REQ && !OD_CMD.we && OD_CMD.index == IDX_BUS_PRESENCE |=> OD_ACK && OD_RDATA == PRESENCE_MAP;
  endproperty
  a_presence_read: assert property (p_presence_read) else $error("availability word wrong");

  property p_band_exit;
    @(posedge CLK) disable iff (!ARST_N) !t_in_band |=> !TORQUE_REACHED;
  endproperty
  a_band_exit: assert property (p_band_exit) else $error("reached while out of band");

  property p_slip_clear;
    @(posedge CLK) disable iff (!ARST_N) !s_over |=> !STATUS_SLIP;
  endproperty
  a_slip_clear: assert property (p_slip_clear) else $error("slip flag without excess slip");

  property p_slip_set;
    @(posedge CLK) disable iff (!ARST_N) s_over && (slip_ms_reg > slip_delay_reg) |=> STATUS_SLIP;
  endproperty
  a_slip_set: assert property (p_slip_set) else $error("slip flag missing after timeout");

  property p_no_reaction;
    @(posedge CLK) disable iff (!ARST_N) !SLIP_REACTION_EN |=> !SLIP_REACTION_REQ && !ERR_LOG_PULSE;
  endproperty
  a_no_reaction: assert property (p_no_reaction) else $error("reaction without configuration");

  property p_div_zero;
    @(posedge CLK) disable iff (!ARST_N) (div_reg == 32'sh0) |=> $stable(PULSE_SCALED);
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("scaled count changed with zero divider");

  // sampled reset term keeps the release edge itself out of the antecedent
  property p_ready_rise;
    @(posedge CLK) disable iff (!ARST_N)
      ARST_N && !DEVICE_READY && (boot_ms_reg >= ready_delay_reg) |=> DEVICE_READY;
  endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("ready late after delay");

  property p_ro_write;
    @(posedge CLK) disable iff (!ARST_N)
      boot_done_reg && OD_REQ && OD_CMD.we && (OD_CMD.index == IDX_BOOT_POS || OD_CMD.index == IDX_BUS_PRESENCE)
      |=> OD_ACK && $stable(boot_pos_reg);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only entry write misbehaved");

  property p_active_present;
    @(posedge CLK) disable iff (!ARST_N) ##2 (BUS_ENABLED & ~PRESENCE_MAP) == 32'h0;
  endproperty
  a_active_present: assert property (p_active_present) else $error("absent bus reported active");

endmodule

// ### dpb_od_master.sv
// far-side model: object dictionary master issuing single-cycle requests
`timescale 1ns/100ps
module dpb_od_master
  import dpb_pkg::*;
(
  // clock
  input  wire logic        clk,
  // request side
  output logic             od_req,
  output dpb_od_req_s      od_cmd,
  // answer side
  input  wire logic        od_ack,
  input  wire logic        od_err,
  input  wire logic [31:0] od_rdata
);
  initial begin
    od_req = 1'b0;
    od_cmd = '0;
  end

  // gap idles the master to model a slow host; released command lines show the
  // inverse of the last value so a stale command never passes for a live one
  task automatic access(input logic we, input logic [15:0] idx, input logic [31:0] d, input int gap,
                        output logic [31:0] rdata, output logic ack, output logic err);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    od_req <= 1'b1;
    od_cmd <= '{we: we, index: idx, wdata: d};
    @(posedge clk);
    od_req <= 1'b0;
    od_cmd <= dpb_od_req_s'(~od_cmd);
    #1;
    rdata = od_rdata;
    ack   = od_ack;
    err   = od_err;
  endtask
endmodule

// ### tb_drive_param_and_bus_select_bank.sv
// testbench: object dictionary, bus select, pulse scaling, torque window and slip monitor tests of the drive parameter and bus select bank
`timescale 1ns/100ps
module tb_drive_param_and_bus_select_bank;
  import dpb_pkg::*;
  localparam logic [31:0] PMAP = 32'h0003_0018;
  localparam logic [31:0] MASK = 32'h0002_0010;
  localparam logic [31:0] BOOT = 32'hfedc_ba98;
  logic clk = 1'b0, arst_n = 1'b0, od_req, od_ack, od_err, torque_reached, pv_mode = 1'b0;
  logic slip_react_en = 1'b0, status_slip, slip_req, err_log, pulse_cw_ccw, device_ready;
  dpb_od_req_s od_cmd;
  logic [31:0] od_rdata, bus_enabled, r;
  logic signed [15:0] torque_target = 16'sh0000, torque_actual = 16'sh4000;
  logic signed [31:0] speed_dev = 32'sh0, slip_limit = 32'sh0, pulse_count = 32'sd5;
  logic signed [31:0] pulse_scaled, encoder_pos = BOOT;
  logic a, e;
  int failures = 0, total_checks = 0, n_react = 0, n_log = 0;
  logic [15:0] idx_t [10] = '{IDX_TORQUE_BAND, IDX_TORQUE_DWELL, IDX_SLIP_DELAY, IDX_PULSE_MULT, IDX_PULSE_DIV,
                              IDX_BOOT_POS, IDX_INPUT_MODE, IDX_READY_DELAY, IDX_BUS_PRESENCE, IDX_BUS_SELECT};
  logic [31:0] rst_t [10] = '{32'(RST_TORQUE_BAND), 32'(RST_TORQUE_DWELL), 32'(RST_SLIP_DELAY), RST_PULSE_MULT,
                              RST_PULSE_DIV, BOOT, RST_INPUT_MODE, RST_READY_DELAY, PMAP, RST_BUS_SELECT};
  logic [31:0] wid_t [10] = '{32'hffff, 32'hffff, 32'hffff, '1, '1, '1, '1, '1, '1, '1};

  always #10 clk = ~clk;

  dpb_od_master i_dpb_od_master (.clk(clk), .od_req(od_req), .od_cmd(od_cmd), .od_ack(od_ack),
                                 .od_err(od_err), .od_rdata(od_rdata));

  dpb_bank #(.MS_CYCLES(5), .PRESENCE_MAP(PMAP), .DISABLE_MASK(MASK)) i_dpb_bank (
    .CLK(clk), .ARST_N(arst_n), .OD_REQ(od_req), .OD_CMD(od_cmd), .OD_ACK(od_ack), .OD_ERR(od_err),
    .OD_RDATA(od_rdata), .TORQUE_TARGET(torque_target), .TORQUE_ACTUAL(torque_actual),
    .TORQUE_REACHED(torque_reached), .PV_MODE(pv_mode), .SPEED_DEVIATION(speed_dev), .SLIP_LIMIT(slip_limit),
    .SLIP_REACTION_EN(slip_react_en), .STATUS_SLIP(status_slip), .SLIP_REACTION_REQ(slip_req),
    .ERR_LOG_PULSE(err_log), .PULSE_COUNT(pulse_count), .PULSE_CW_CCW(pulse_cw_ccw),
    .PULSE_SCALED(pulse_scaled), .ENCODER_POS(encoder_pos), .DEVICE_READY(device_ready),
    .BUS_ENABLED(bus_enabled));

  // slip pulses are counted all run long, but a second pulse after the count check in the slip test is not caught
  always @(posedge clk) begin
    if (slip_req === 1'b1) n_react++;
    if (err_log === 1'b1) n_log++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    i_dpb_od_master.access(1'b1, idx, d, 0, r, a, e);
    check(32'(a), 32'h1);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input int gap);
    i_dpb_od_master.access(1'b0, idx, 32'h0, gap, r, a, e);
    check(32'(a), 32'h1);
    check(r, exp);
  endtask

  task automatic wait_look(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    complete_run();
  end

  initial begin
    @(posedge clk);
    #1;
    check(32'(device_ready), 32'h0);
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    wait_look(4);
    check(32'(device_ready), 32'h1);
    check(pulse_scaled, 32'd640);
    for (int i = 0; i < 10; i++) rd(idx_t[i], rst_t[i], i % 3);
    i_dpb_od_master.access(1'b0, 16'h2100, 32'h0, 0, r, a, e);
    check({30'h0, a, e}, 32'h1);
    check(r, 32'h0);
    $display("test reset values done");

    for (int i = 0; i < 10; i++) wr(idx_t[i], 32'ha5c3_5a3c);
    for (int i = 0; i < 10; i++) rd(idx_t[i], (i == 5 || i == 8) ? rst_t[i] : 32'ha5c3_5a3c & wid_t[i], 0);
    $display("test access kinds done");

    wr(IDX_BUS_SELECT, 32'h0);
    wait_look(2);
    check(bus_enabled, 32'h0000_0008);
    wr(IDX_BUS_SELECT, 32'hffff_ffff);
    wait_look(2);
    check(bus_enabled, 32'h0002_0018);
    rd(IDX_BUS_SELECT, 32'hffff_ffff, 0);
    $display("test bus select done");

    wr(IDX_PULSE_MULT, 32'hffff_fffd);
    wr(IDX_PULSE_DIV, 32'h2);
    @(posedge clk);
    pulse_count <= 32'sd7;
    wait_look(4);
    check(pulse_scaled, 32'hffff_fff6);
    wr(IDX_PULSE_DIV, 32'h0);
    @(posedge clk);
    pulse_count <= 32'sd9;
    wait_look(4);
    check(pulse_scaled, 32'hffff_fff6);
    wr(IDX_INPUT_MODE, 32'h1);
    wait_look(2);
    check(32'(pulse_cw_ccw), 32'h1);
    wr(IDX_INPUT_MODE, 32'h0);
    wait_look(2);
    check(32'(pulse_cw_ccw), 32'h0);
    $display("test pulse scaling done");

    wr(IDX_TORQUE_BAND, 32'h000a);
    wr(IDX_TORQUE_DWELL, 32'h0002);
    @(posedge clk);
    torque_target <= 16'sd100;
    torque_actual <= 16'sd110;
    wait_look(3);
    check(32'(torque_reached), 32'h0);
    wait_look(20);
    check(32'(torque_reached), 32'h1);
    @(posedge clk);
    torque_actual <= 16'sd89;
    wait_look(3);
    check(32'(torque_reached), 32'h0);
    wr(IDX_TORQUE_BAND, 32'hffff);
    @(posedge clk);
    torque_actual <= 16'sd100;
    wait_look(25);
    check(32'(torque_reached), 32'h0);
    $display("test torque window done");

    wr(IDX_SLIP_DELAY, 32'h0002);
    @(posedge clk);
    slip_limit <= 32'sd50;
    speed_dev <= -32'sd60;
    slip_react_en <= 1'b1;
    wait_look(30);
    check(32'(status_slip), 32'h0);
    @(posedge clk);
    pv_mode <= 1'b1;
    wait_look(6);
    check(32'(status_slip), 32'h0);
    wait_look(20);
    check(32'(status_slip), 32'h1);
    check(n_react, 32'd1);
    check(n_log, 32'd1);
    @(posedge clk);
    speed_dev <= -32'sd50;
    wait_look(3);
    check(32'(status_slip), 32'h0);
    $display("test slip monitor done");
    complete_run();
  end
endmodule
